// ==== logic/ldr_mem.sv ====
// Large dual-port memory: 4096 x 144 storage, two fabric ports, AXI4-Lite config.
// Assumes both ports and the register bus run on aclk; port inputs come from
// fabric logic on that clock and need no synchroniser.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Storage is 589,824 bits; every geometry addresses the same array.
// - Modes: true dual-port, simple dual-port, single-port, FIFO.
// - No preload; contents unknown after power-up until written.
// - Address, data, select and mask are registered before use.
// - Each read path has an output register that can be bypassed.
// - Geometries 64Kx9, 32Kx18, 16Kx36, 8Kx72, 4Kx144 and byte variants.
// - 144-bit geometry not allowed in true dual-port mode.
// - Simple dual-port mixes 9..72 freely; 144 pairs only with 144.
// - True dual-port: each port independently picks 9, 18, 36 or 72.
// - One read/write select per port; no separate read gate.
// - Lane written only when write select and lane mask both high; x9 needs the write select alone.
// - Byte masking offered in 18-, 36- and 72-bit widths.
// - Mask bit i gates data bits 9i+8 down to 9i.
// - 144-bit mode joins both ports' masks into one 16-bit mask.
// - Combined mask keeps nine-bit lanes up to bits 143..135.
// - Any mask pattern is accepted, including all zeros.
// - In 8-bit byte widths masks gate consecutive 8-bit bytes.
// - All input registers of a port share one clock.
// - Each port has its own clock enable, read/write select and clear.
// - 72 data in and out per port; 144-bit mode uses both.
// - Independent mode: each port's registers follow its own enable.
// - In/out mode: output registers follow the other port's enable.
module ldr_mem #(
    parameter int AXI_AW = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Memory ports
    input wire ldr_pkg::ldr_port_in_s port_a,
    input wire ldr_pkg::ldr_port_in_s port_b,
    output logic [ldr_pkg::LDR_PORT_W-1:0] dout_a,
    output logic [ldr_pkg::LDR_PORT_W-1:0] dout_b
);
    import ldr_pkg::*;

    if (AXI_AW < 3 || AXI_AW > 32) begin : g_bad_aw
        $error("AXI_AW must lie between 3 and 32");
    end

    // =========================================================================
    // Helpers
    function automatic logic [4:0] geo_lanes(input logic [2:0] g);
        return 5'h1 << g;
    endfunction

    function automatic ldr_cfg_s to_cfg(input logic [31:0] w);
        ldr_cfg_s c;
        c.mode = ldr_mode_e'(w[LDR_CTRL_MODE_LSB +: 2]);
        c.geo_a = w[LDR_CTRL_GEOA_LSB +: 3];
        c.geo_b = w[LDR_CTRL_GEOB_LSB +: 3];
        c.b8_a = w[LDR_CTRL_B8A];
        c.b8_b = w[LDR_CTRL_B8B];
        c.obyp_a = w[LDR_CTRL_OBYPA];
        c.obyp_b = w[LDR_CTRL_OBYPB];
        c.ioclk = w[LDR_CTRL_IOCLK];
        return c;
    endfunction

    // Refuses geometry pairings the array cannot serve
    function automatic logic cfg_ok(input ldr_cfg_s c);
        logic ok;
        logic wa;
        logic wb;
        wa = (c.geo_a == LDR_GEO_X144);
        wb = (c.geo_b == LDR_GEO_X144);
        ok = 1'b0;
        if (c.geo_a <= LDR_GEO_X144 && c.geo_b <= LDR_GEO_X144) begin
            unique case (c.mode)
                LDR_TDP: ok = !wa && !wb;
                LDR_SDP: ok = (wa == wb);
                LDR_SP: ok = !wa;
                LDR_FIFO: ok = !wa && (c.geo_a == c.geo_b);
            endcase
        end
        return ok;
    endfunction

    function automatic logic reg_hit(input logic [AXI_AW-1:0] a, input logic [7:0] ofs);
        return 32'(a[AXI_AW-1:2]) == 32'(ofs[7:2]);
    endfunction

    // Gathers the accessed lanes into a right-aligned read word
    function automatic logic [143:0] rd_fmt(input logic [143:0] w, input logic [3:0] base,
                                            input logic [2:0] g, input logic b8);
        logic [143:0] r;
        int n;
        r = '0;
        n = 1 << g;
        for (int k = 0; k < LDR_LANES; k++) begin
            if (k < n) begin
                if (b8) begin
                    r[8*k +: 8] = w[LDR_LANE_W*(int'(base)+k) +: 8];
                end else begin
                    r[LDR_LANE_W*k +: LDR_LANE_W] = w[LDR_LANE_W*(int'(base)+k) +: LDR_LANE_W];
                end
            end
        end
        return r;
    endfunction

    // =========================================================================
    // Configuration view
    logic [31:0] ctrl_q;
    ldr_cfg_s cfg;
    logic wide;
    logic fifo;
    logic [2:0] geo [2];
    logic b8 [2];
    logic obyp [2];
    logic [4:0] nl;

    assign cfg = to_cfg(ctrl_q);
    assign wide = (cfg.mode == LDR_SDP) && (cfg.geo_a == LDR_GEO_X144);
    assign fifo = (cfg.mode == LDR_FIFO);
    assign geo[0] = cfg.geo_a;
    assign geo[1] = cfg.geo_b;
    assign b8[0] = cfg.b8_a;
    assign b8[1] = cfg.b8_b;
    assign obyp[0] = cfg.obyp_a;
    assign obyp[1] = cfg.obyp_b;
    assign nl = geo_lanes(cfg.geo_a);

    // =========================================================================
    // Port acceptance and input capture
    ldr_port_in_s pin [2];
    ldr_stg_s stg_q [2];
    logic acc [2];
    logic [15:0] la_in [2];
    logic [143:0] wd_in [2];
    logic [15:0] wm_in [2];
    logic [15:0] wptr_q;
    logic [15:0] rptr_q;
    logic [16:0] cnt_q;
    logic [17:0] used;
    logic fifo_full;
    logic fifo_empty;
    logic push;
    logic pop;
    logic land;
    logic fifo_clr;

    assign pin[0] = port_a;
    assign pin[1] = port_b;

    // One select per port: high writes, low reads
    assign acc[0] = pin[0].cen && !pin[0].clr &&
                    (pin[0].wr ? !(fifo && fifo_full)
                               : (cfg.mode == LDR_TDP || cfg.mode == LDR_SP));
    assign acc[1] = pin[1].cen && !pin[1].clr && (cfg.mode != LDR_SP) &&
                    (pin[1].wr ? (cfg.mode == LDR_TDP) : !(fifo && fifo_empty));
    assign push = acc[0] && pin[0].wr && fifo;
    assign pop = acc[1] && !pin[1].wr && fifo;

    // Word address scaled to a lane address in the shared array
    assign la_in[0] = fifo ? wptr_q : 16'(pin[0].addr << geo[0]);
    assign la_in[1] = fifo ? rptr_q : 16'(pin[1].addr << geo[1]);
    // Wide write takes both ports' data and masks
    assign wd_in[0] = wide ? {pin[1].din, pin[0].din} : {72'h0, pin[0].din};
    assign wd_in[1] = {72'h0, pin[1].din};
    assign wm_in[0] = wide ? {pin[1].mask, pin[0].mask} : {8'hff, pin[0].mask};
    assign wm_in[1] = {8'hff, pin[1].mask};

    // Input registers of both ports share aclk and load on their enable
    always_ff @(posedge aclk) begin
        for (int p = 0; p < 2; p++) begin
            if (!aresetn || pin[p].clr) begin
                stg_q[p] <= '0;
            end else begin
                stg_q[p].vld <= acc[p];
                if (acc[p]) begin
                    stg_q[p].wr <= pin[p].wr;
                    stg_q[p].la <= la_in[p];
                    stg_q[p].wd <= wd_in[p];
                    stg_q[p].wm <= wm_in[p];
                end
            end
        end
    end

    // =========================================================================
    // Storage array, never reset or preloaded
    logic [143:0] mem [LDR_WORDS];

    always_ff @(posedge aclk) begin
        for (int p = 0; p < 2; p++) begin
            if (stg_q[p].vld && stg_q[p].wr) begin
                for (int j = 0; j < LDR_LANES; j++) begin
                    automatic int k = j - int'(stg_q[p].la[3:0]);
                    // Lane in window and mask set, or no mask in x9
                    if (k >= 0 && k < int'(geo_lanes(geo[p])) &&
                        (geo[p] == LDR_GEO_X9 || stg_q[p].wm[k])) begin
                        if (b8[p]) begin
                            mem[stg_q[p].la[15:4]][LDR_LANE_W*j +: LDR_LANE_W] <=
                                {1'b0, stg_q[p].wd[8*k +: 8]};
                        end else begin
                            mem[stg_q[p].la[15:4]][LDR_LANE_W*j +: LDR_LANE_W] <=
                                stg_q[p].wd[LDR_LANE_W*k +: LDR_LANE_W];
                        end
                    end
                end
            end
        end
    end

    // =========================================================================
    // Read path: core register, then optional output register
    logic [143:0] core_q [2];
    logic [143:0] out_q [2];
    logic [143:0] rd_sel [2];
    logic oen [2];
    logic [143:0] rd_word;

    // Stored word under port A's staged read, for the latency check
    assign rd_word = mem[stg_q[0].la[15:4]];

    // Output registers follow own enable or the other port's
    assign oen[0] = cfg.ioclk ? pin[1].cen : pin[0].cen;
    assign oen[1] = cfg.ioclk ? pin[0].cen : pin[1].cen;

    always_ff @(posedge aclk) begin
        for (int p = 0; p < 2; p++) begin
            if (!aresetn || pin[p].clr) begin
                core_q[p] <= '0;
            end else if (stg_q[p].vld && !stg_q[p].wr) begin
                core_q[p] <= rd_fmt(mem[stg_q[p].la[15:4]], stg_q[p].la[3:0], geo[p], b8[p]);
            end
        end
    end

    always_ff @(posedge aclk) begin
        for (int p = 0; p < 2; p++) begin
            if (!aresetn || pin[p].clr) begin
                out_q[p] <= '0;
            end else if (oen[p]) begin
                out_q[p] <= core_q[p];
            end
        end
    end

    assign rd_sel[0] = obyp[0] ? core_q[0] : out_q[0];
    assign rd_sel[1] = obyp[1] ? core_q[1] : out_q[1];
    // Wide read spreads over both ports' outputs
    assign dout_a = wide ? rd_sel[1][71:0] : rd_sel[0][71:0];
    assign dout_b = wide ? rd_sel[1][143:72] : rd_sel[1][71:0];

    // =========================================================================
    // FIFO pointers; fill counts a push only once its write has landed
    assign land = fifo && stg_q[0].vld && stg_q[0].wr;
    assign used = 18'(cnt_q) + (land ? 18'(nl) : 18'h0);
    assign fifo_full = (used + 18'(nl)) > LDR_FIFO_LANES;
    assign fifo_empty = cnt_q < 17'(nl);

    always_ff @(posedge aclk) begin
        if (!aresetn || fifo_clr || !fifo) begin
            wptr_q <= 16'h0;
            rptr_q <= 16'h0;
            cnt_q <= 17'h0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 16'(nl);
            end
            if (pop) begin
                rptr_q <= rptr_q + 16'(nl);
            end
            cnt_q <= cnt_q + (land ? 17'(nl) : 17'h0) - (pop ? 17'(nl) : 17'h0);
        end
    end

    // =========================================================================
    // AXI4-Lite slave
    logic aw_full_q;
    logic w_full_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic do_wr;
    logic wr_ctrl;
    logic wr_stat;
    logic [31:0] smask;
    logic [31:0] ctrl_new;
    logic legal;
    logic [31:0] stat;

    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    assign do_wr = aw_full_q && w_full_q && !bvalid_q;
    assign wr_ctrl = do_wr && reg_hit(awaddr_q, LDR_CTRL_OFS);
    assign wr_stat = do_wr && reg_hit(awaddr_q, LDR_STAT_OFS);
    assign smask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign ctrl_new = (ctrl_q & ~smask) | (wdata_q & smask);
    assign legal = cfg_ok(to_cfg(ctrl_new));
    assign fifo_clr = wr_ctrl && wstrb_q[2] && wdata_q[LDR_CTRL_FCLR];

    always_comb begin
        stat = 32'h0;
        stat[LDR_STAT_ERR] = err_q;
        stat[LDR_STAT_EMPTY] = fifo_empty;
        stat[LDR_STAT_FULL] = fifo_full;
        stat[LDR_STAT_CNT_LSB +: 17] = cnt_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_wr) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= LDR_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= ((wr_ctrl && legal) || wr_stat) ? LDR_RESP_OKAY : LDR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Illegal geometry keeps the old setting and raises a sticky flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= LDR_CTRL_RST;
        end else if (wr_ctrl && legal) begin
            ctrl_q <= ctrl_new & ~(32'h1 << LDR_CTRL_FCLR);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q <= 1'b0;
        end else if (wr_ctrl && !legal) begin
            err_q <= 1'b1;
        end else if (wr_stat && wstrb_q[0] && wdata_q[LDR_STAT_ERR]) begin
            err_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= LDR_RESP_OKAY;
            rdata_q <= 32'h0;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= LDR_RESP_OKAY;
            if (reg_hit(s_axi_araddr, LDR_CTRL_OFS)) begin
                rdata_q <= ctrl_q;
            end else if (reg_hit(s_axi_araddr, LDR_STAT_OFS)) begin
                rdata_q <= stat;
            end else begin
                rdata_q <= 32'h0;
                rresp_q <= LDR_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // =========================================================================
    // Checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_capture;
        acc[0] |=> stg_q[0].vld && stg_q[0].wr == $past(pin[0].wr);
    endproperty
    a_capture: assert property (p_capture) else $error("accepted access not captured");
    property p_sp_b_idle;
        cfg.mode == LDR_SP && $stable(ctrl_q) |=> !stg_q[1].vld;
    endproperty
    a_sp_b_idle: assert property (p_sp_b_idle) else $error("port B active in single-port");
    property p_no_tdp_wide;
        cfg.mode == LDR_TDP |-> cfg.geo_a != LDR_GEO_X144 && cfg.geo_b != LDR_GEO_X144;
    endproperty
    a_no_tdp_wide: assert property (p_no_tdp_wide) else $error("144-bit in dual-port");
    property p_sdp_pair;
        cfg.mode == LDR_SDP |-> (cfg.geo_a == LDR_GEO_X144) == (cfg.geo_b == LDR_GEO_X144);
    endproperty
    a_sdp_pair: assert property (p_sdp_pair) else $error("144-bit paired with narrow");
    property p_outreg;
        !obyp[1] && oen[1] && !pin[1].clr |=> out_q[1] == $past(core_q[1]);
    endproperty
    a_outreg: assert property (p_outreg) else $error("output register missed load");
    property p_sdp_a_read;
        cfg.mode == LDR_SDP && pin[0].cen && !pin[0].wr |=> !stg_q[0].vld;
    endproperty
    a_sdp_a_read: assert property (p_sdp_a_read) else $error("read taken on write port");
    property p_clear;
        pin[0].clr |=> !stg_q[0].vld && core_q[0] == 144'h0 && out_q[0] == 144'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left port state");
    property p_fifo_bound;
        cnt_q <= 17'(LDR_FIFO_LANES);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo fill above capacity");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
    property p_read_lat;
        stg_q[0].vld && !stg_q[0].wr && !pin[0].clr && obyp[0] && !wide ##1 $stable(ctrl_q)
            |-> dout_a == 72'(rd_fmt($past(rd_word), $past(stg_q[0].la[3:0]), geo[0], b8[0]));
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("bypassed read not shown");

    c_wide_wr: cover property (wide && stg_q[0].vld && stg_q[0].wr);
    c_fifo_full: cover property (fifo && fifo_full);
    c_byte8_rd: cover property (b8[1] && stg_q[1].vld && !stg_q[1].wr);
    c_cfg_err: cover property (wr_ctrl && !legal);

endmodule

`default_nettype wire

// ==== logic/ldr_pkg.sv ====
// Constants, field layouts and carriers for the large dual-port memory block.
// Assumes one clock domain; fabric logic drives the ports on that same clock.
package ldr_pkg;

    // =========================================================================
    // Storage geometry
    localparam int LDR_TOTAL_BITS = 589824;
    localparam int LDR_LANES = 16;
    localparam int LDR_LANE_W = 9;
    localparam int LDR_WORDS = LDR_TOTAL_BITS / (LDR_LANES * LDR_LANE_W);
    localparam int LDR_ADDR_W = 16;
    localparam int LDR_PORT_W = 72;
    localparam int LDR_MASK_W = 8;
    localparam logic [17:0] LDR_FIFO_LANES = 18'd65536;

    // Geometry codes: lanes per access is 1 << code
    localparam logic [2:0] LDR_GEO_X9 = 3'h0;
    localparam logic [2:0] LDR_GEO_X18 = 3'h1;
    localparam logic [2:0] LDR_GEO_X36 = 3'h2;
    localparam logic [2:0] LDR_GEO_X72 = 3'h3;
    localparam logic [2:0] LDR_GEO_X144 = 3'h4;

    typedef enum logic [1:0] {
        LDR_TDP = 2'h0,
        LDR_SDP = 2'h1,
        LDR_SP = 2'h2,
        LDR_FIFO = 2'h3
    } ldr_mode_e;

    // =========================================================================
    // Register map
    localparam logic [7:0] LDR_CTRL_OFS = 8'h00;
    localparam logic [7:0] LDR_STAT_OFS = 8'h04;
    localparam logic [31:0] LDR_CTRL_RST = 32'h0;
    localparam int LDR_CTRL_MODE_LSB = 0;
    localparam int LDR_CTRL_GEOA_LSB = 2;
    localparam int LDR_CTRL_GEOB_LSB = 5;
    localparam int LDR_CTRL_B8A = 8;
    localparam int LDR_CTRL_B8B = 9;
    localparam int LDR_CTRL_OBYPA = 10;
    localparam int LDR_CTRL_OBYPB = 11;
    localparam int LDR_CTRL_IOCLK = 12;
    localparam int LDR_CTRL_FCLR = 16;
    localparam int LDR_STAT_ERR = 0;
    localparam int LDR_STAT_EMPTY = 1;
    localparam int LDR_STAT_FULL = 2;
    localparam int LDR_STAT_CNT_LSB = 4;
    localparam logic [1:0] LDR_RESP_OKAY = 2'h0;
    localparam logic [1:0] LDR_RESP_SLVERR = 2'h2;

    // =========================================================================
    // Carriers
    typedef struct packed {
        logic cen;
        logic clr;
        logic wr;
        logic [LDR_ADDR_W-1:0] addr;
        logic [LDR_PORT_W-1:0] din;
        logic [LDR_MASK_W-1:0] mask;
    } ldr_port_in_s;

    typedef struct packed {
        ldr_mode_e mode;
        logic [2:0] geo_a;
        logic [2:0] geo_b;
        logic b8_a;
        logic b8_b;
        logic obyp_a;
        logic obyp_b;
        logic ioclk;
    } ldr_cfg_s;

    typedef struct packed {
        logic vld;
        logic wr;
        logic [LDR_ADDR_W-1:0] la;
        logic [2*LDR_PORT_W-1:0] wd;
        logic [2*LDR_MASK_W-1:0] wm;
    } ldr_stg_s;

endpackage

// ==== verification/ldr_fab.sv ====
// Fabric model: drives both memory ports, one access per call.
// Assumes the memory samples its ports on the rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none
module ldr_fab (
    // Clock
    input wire logic aclk,
    // Memory ports
    output ldr_pkg::ldr_port_in_s port_a,
    output ldr_pkg::ldr_port_in_s port_b
);
    import ldr_pkg::*;
    // ==========
    // Access: en picks ports, data and mask split A low, B high
    initial begin
        port_a = '0;
        port_b = '0;
    end
    task automatic op(input logic [1:0] en, input logic wr, input logic [15:0] ad,
                      input logic [143:0] d, input logic [15:0] m);
        @(posedge aclk);
        port_a <= '{en[0], 1'b0, wr, ad, d[71:0], m[7:0]};
        port_b <= '{en[1], 1'b0, wr, ad, d[143:72], m[15:8]};
        @(posedge aclk);
        // Released lines turn over, never keep stale values
        port_a <= '{1'b0, 1'b0, ~wr, ~ad, ~d[71:0], ~m[7:0]};
        port_b <= '{1'b0, 1'b0, ~wr, ~ad, ~d[143:72], ~m[15:8]};
        repeat (2) @(posedge aclk);
        #1;
    endtask
    // Clear: one-cycle clear pulse on the ports picked by en
    task automatic wipe(input logic [1:0] en);
        @(posedge aclk);
        port_a.clr <= en[0];
        port_b.clr <= en[1];
        @(posedge aclk);
        port_a.clr <= 1'b0;
        port_b.clr <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// ==== verification/large_dual_port_ram_tb.sv ====
// Bench for the large memory: register bus tasks plus fabric port accesses.
// Assumes ldr_fab drives the ports; all on one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module large_dual_port_ram_tb;
    import ldr_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    ldr_port_in_s port_a, port_b;
    logic [LDR_PORT_W-1:0] dout_a, dout_b;
    int err_count, n_tests;
    ldr_mem dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port_a(port_a), .port_b(port_b),
        .dout_a(dout_a), .dout_b(dout_b));
    ldr_fab fab (.aclk(aclk), .port_a(port_a), .port_b(port_b));
    // ==========
    // Checking and closing
    task automatic chk(input logic [143:0] got, input logic [143:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic stall();
        err_count++;
        $display("unexpected at %0t: bus timeout", $time);
        wrap_up();
    endtask
    // ==========
    // Register bus master
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
        if (i == 40) stall();
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (i == 40) stall();
    endtask
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        logic [31:0] rd, cur;
        logic [1:0] rs;
        logic [143:0] e, w;
        logic [31:0] cfg [5];
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axr(LDR_CTRL_OFS, rd, rs);
        chk(rd, LDR_CTRL_RST);
        axr(8'h08, rd, rs);
        chk({rs, rd}, {LDR_RESP_SLVERR, 32'h0});
        axw(LDR_CTRL_OFS, 32'h0000_0c0c, rs);
        chk(rs, LDR_RESP_OKAY);
        w = 144'h5a5a_0f0f_3c3c_9669_c3a5_1234_5678_9abc_def0;
        fab.op(2'b01, 1'b1, 16'h1, w, 16'h00ff);
        fab.op(2'b01, 1'b0, 16'h1, '0, 16'h00ff);
        chk(dout_a, w[71:0]);
        fab.op(2'b01, 1'b1, 16'h1, ~w, 16'h005a);
        fab.op(2'b01, 1'b1, 16'h1, '0, 16'h0000);
        e = w;
        for (int k = 0; k < 8; k++) if (8'h5a >> k & 1) e[9*k+:9] = ~w[9*k+:9];
        fab.op(2'b01, 1'b0, 16'h1, '0, 16'h00ff);
        chk(dout_a, e[71:0]);
        fab.op(2'b10, 1'b0, 16'h9, '0, 16'hffff);
        chk(dout_b[8:0], e[17:9]);
        fab.op(2'b10, 1'b1, 16'hf, {63'h0, 9'h1a5, 72'h0}, 16'hff00);
        e[71:63] = 9'h1a5;
        fab.op(2'b01, 1'b0, 16'h1, '0, 16'h00ff);
        chk(dout_a, e[71:0]);
        fab.wipe(2'b01);
        chk(dout_a, '0);
        axw(LDR_CTRL_OFS, 32'h0000_000c, rs);
        fab.op(2'b01, 1'b0, 16'h1, '0, 16'h00ff);
        fab.op(2'b01, 1'b0, 16'h2, '0, 16'h00ff);
        chk(dout_a, e[71:0]);
        cfg = '{32'hc10, 32'hc71, 32'hc0e, 32'hc6f, 32'hc91};
        cur = 32'h0000_000c;
        foreach (cfg[k]) begin
            axw(LDR_CTRL_OFS, cfg[k], rs);
            if (k >= 2) cur = cfg[k];
            chk(rs, (k >= 2) ? LDR_RESP_OKAY : LDR_RESP_SLVERR);
            axr(LDR_CTRL_OFS, rd, rs);
            chk(rd, cur);
        end
        axr(LDR_STAT_OFS, rd, rs);
        chk(rd[LDR_STAT_ERR], 1'b1);
        fab.op(2'b01, 1'b1, 16'h2, w, 16'hffff);
        fab.op(2'b01, 1'b1, 16'h2, ~w, 16'h8001);
        e = w;
        e[8:0] = ~w[8:0];
        e[143:135] = ~w[143:135];
        fab.op(2'b10, 1'b0, 16'h2, '0, 16'hffff);
        chk({dout_b, dout_a}, e);
        axw(LDR_CTRL_OFS, 32'h0000_0c6f, rs);
        fab.op(2'b01, 1'b1, 16'h0, w, 16'hffff);
        axr(LDR_STAT_OFS, rd, rs);
        chk(rd[LDR_STAT_CNT_LSB+:17], 17'd8);
        fab.op(2'b10, 1'b0, 16'h0, '0, 16'hffff);
        chk(dout_b, w[71:0]);
        axw(LDR_CTRL_OFS, 32'h0000_050a, rs);
        fab.op(2'b01, 1'b1, 16'h3, w, 16'hffff);
        fab.op(2'b01, 1'b0, 16'h3, '0, 16'hffff);
        chk(dout_a, {40'h0, w[31:0]});
        axw(LDR_CTRL_OFS, 32'h0000_106c, rs);
        fab.op(2'b01, 1'b0, 16'h0, '0, 16'hffff);
        fab.op(2'b10, 1'b0, 16'h0, '0, 16'hffff);
        chk(dout_a, w[71:0]);
        wrap_up();
    end
endmodule
`default_nettype wire
